// ==== hw/sdci_device.sv ====
// sdram device end: command decode, banks, bursts, refresh, masking
// Function
// - active takes row; read/write take column, flag
// - precharge closes all banks or one
// - load mode copies address; banks idle
// - gate low ignores edges, low power
// - inputs sampled at rising edge; gate asynchronous
// - chip select high ignores commands
// - read mask high floats lanes two clocks later
// - write mask applies same cycle per byte
// - read bursts from open row at column
// - read auto precharge closes row after burst
// - write bursts, optional auto precharge after
// - controller waits precharge time, activates first
// - auto precharge chosen per command only
// - auto refresh internal row; wait cycle time
// - controller refreshes 4096 times per 64ms
// - gate low at refresh enters self refresh
// - controller holds self refresh minimum time
// - after self refresh two nops, wait
// - controller issues one auto refresh after self refresh
// - burst terminate cuts latest burst short
// - inhibit accepts nothing, ongoing work continues
// - active opens row until precharge
// - refresh code: gate high auto, low self
`timescale 1ns/10ps
module sdci_device
	import sdci_pkg::*;
#(
	parameter int MEM_WORDS = 4096
) (
	input  wire logic                    mclk,
	input  wire logic                    resetn,
	sdci_if.device                       pins,
	output logic     [MODE_W-1:0]        mode_reg,
	output logic     [NUM_BANKS-1:0]     bank_open,
	output logic                         self_refresh,
	output logic     [ROW_W-1:0]         refresh_row
);
	localparam int AW = $clog2(MEM_WORDS);
	// storage must be a power of two the address slice can reach
	if (MEM_WORDS < 2 || MEM_WORDS > 65536 ||
		(1 << AW) != MEM_WORDS) begin : g_bad_words
		$error("MEM_WORDS must be a power of two from 2 to 65536");
	end
	typedef enum logic [1:0] {SDCI_IDLE, SDCI_READ, SDCI_WRITE} sdci_burst_t;

	// gate is asynchronous: two flops before use
	logic gate_meta;
	logic gate_sync;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			gate_meta <= 1'b0;
			gate_sync <= 1'b0;
		end else begin
			gate_meta <= pins.clk_gate;
			gate_sync <= gate_meta;
		end
	end

	sdci_cmd_t cmd;
	always_comb begin
		if (pins.chip_select_n)
			cmd = SDCI_CMD_INHIBIT;
		else
			cmd = sdci_cmd_t'({1'b0, pins.row_strobe_n, pins.col_strobe_n,
				pins.write_strobe_n});
	end

	// refresh code two edges back, aligned with the synchronised gate
	logic [1:0] refresh_hist;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			refresh_hist <= 2'h0;
		else
			refresh_hist <= {refresh_hist[0], cmd == SDCI_CMD_REFRESH};
	end

	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [ROW_W-1:0]  open_row [NUM_BANKS];
	logic [ROW_W-1:0]  next_open_row [NUM_BANKS];
	sdci_burst_t       burst, next_burst;
	logic [BANK_W-1:0] burst_bank, next_burst_bank;
	logic [COL_W-1:0]  burst_col, next_burst_col;
	logic [2:0]        burst_left, next_burst_left;
	logic              burst_ap, next_burst_ap;
	logic [NUM_BANKS-1:0] next_bank_open;
	logic [MODE_W-1:0] next_mode_reg;
	logic              next_self_refresh;
	logic [ROW_W-1:0]  next_refresh_row;
	logic [1:0]        mask_pipe [RD_MASK_LAT];
	logic [DATA_W-1:0] rd_pipe [RD_MASK_LAT];
	logic [RD_MASK_LAT-1:0] rd_valid;
	logic              wr_now;
	logic              rd_now;
	logic [AW-1:0]     waddr;
	logic [AW-1:0]     raddr;
	logic [DATA_W-1:0] wdata;

	always_comb begin
		next_burst = burst;
		next_burst_bank = burst_bank;
		next_burst_col = burst_col;
		next_burst_left = burst_left;
		next_burst_ap = burst_ap;
		next_bank_open = bank_open;
		next_mode_reg = mode_reg;
		next_self_refresh = self_refresh;
		next_refresh_row = refresh_row;
		for (int b = 0; b < NUM_BANKS; b++)
			next_open_row[b] = open_row[b];
		wr_now = 1'b0;
		rd_now = 1'b0;
		if (self_refresh) begin
			// all inputs but the gate ignored; row counter runs internally
			next_refresh_row = refresh_row + 1'b1;
			if (gate_sync)
				next_self_refresh = 1'b0;
		end else if (gate_sync) begin
			// ongoing burst keeps stepping
			if (burst != SDCI_IDLE) begin
				rd_now = (burst == SDCI_READ);
				wr_now = (burst == SDCI_WRITE);
				next_burst_col = burst_col + 1'b1;
				next_burst_left = burst_left - 1'b1;
				if (burst_left == 3'h1) begin
					next_burst = SDCI_IDLE;
					if (burst_ap)
						next_bank_open[burst_bank] = 1'b0;
				end
			end
			unique case (cmd)
			SDCI_CMD_ACTIVE: begin
				next_bank_open[pins.bank_select_lines] = 1'b1;
				next_open_row[pins.bank_select_lines] =
					pins.address_lines;
			end
			SDCI_CMD_READ, SDCI_CMD_WRITE: begin
				next_burst = (cmd == SDCI_CMD_READ) ?
					SDCI_READ : SDCI_WRITE;
				next_burst_bank = pins.bank_select_lines;
				next_burst_col = pins.address_lines[COL_W-1:0];
				next_burst_ap = pins.address_lines[AP_BIT];
				next_burst_left = 3'(BURST_LEN);
			end
			SDCI_CMD_BURST_END: next_burst = SDCI_IDLE;
			SDCI_CMD_PRECHARGE: begin
				if (pins.address_lines[AP_BIT])
					next_bank_open = '0;
				else
					next_bank_open[pins.bank_select_lines] = 1'b0;
			end
			SDCI_CMD_REFRESH: begin
				next_refresh_row = refresh_row + 1'b1;
			end
			SDCI_CMD_LOAD_MODE: begin
				if (bank_open == '0)
					next_mode_reg = pins.address_lines;
			end
			SDCI_CMD_NOP, SDCI_CMD_INHIBIT: ;
			default: ;
			endcase
		end else if (refresh_hist[1]) begin
			// gate was low at the edge that carried the refresh code
			next_self_refresh = 1'b1;
		end
	end

	always_comb begin
		raddr = AW'({burst_bank, open_row[burst_bank], burst_col});
		waddr = raddr;
		wdata = pins.ctrl_data_out;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			burst <= SDCI_IDLE;
			burst_bank <= '0;
			burst_col <= '0;
			burst_left <= '0;
			burst_ap <= 1'b0;
			bank_open <= '0;
			mode_reg <= '0;
			self_refresh <= 1'b0;
			refresh_row <= ROW_ZERO;
			for (int b = 0; b < NUM_BANKS; b++)
				open_row[b] <= ROW_ZERO;
		end else begin
			burst <= next_burst;
			burst_bank <= next_burst_bank;
			burst_col <= next_burst_col;
			burst_left <= next_burst_left;
			burst_ap <= next_burst_ap;
			bank_open <= next_bank_open;
			mode_reg <= next_mode_reg;
			self_refresh <= next_self_refresh;
			refresh_row <= next_refresh_row;
			for (int b = 0; b < NUM_BANKS; b++)
				open_row[b] <= next_open_row[b];
		end
	end

	// storage array, byte writes masked in the data cycle
	always_ff @(posedge mclk) begin
		if (wr_now && !pins.low_byte_mask)
			mem[waddr][7:0] <= wdata[7:0];
		if (wr_now && !pins.high_byte_mask)
			mem[waddr][15:8] <= wdata[15:8];
	end

	// read data and masks pipelined two clocks
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_valid <= '0;
			for (int i = 0; i < RD_MASK_LAT; i++) begin
				mask_pipe[i] <= 2'h3;
				rd_pipe[i] <= 16'h0000;
			end
		end else begin
			rd_valid <= {rd_valid[RD_MASK_LAT-2:0], rd_now};
			mask_pipe[0] <= {pins.high_byte_mask, pins.low_byte_mask};
			rd_pipe[0] <= mem[raddr];
			for (int i = 1; i < RD_MASK_LAT; i++) begin
				mask_pipe[i] <= mask_pipe[i-1];
				rd_pipe[i] <= rd_pipe[i-1];
			end
		end
	end

	assign pins.dev_data_out = rd_pipe[RD_MASK_LAT-1];
	assign pins.dev_data_oe = {2{rd_valid[RD_MASK_LAT-1]}} &
		~mask_pipe[RD_MASK_LAT-1];
endmodule : sdci_device

// ==== hw/sdci_pkg.sv ====
// shared constants and types for the sdram command interface
package sdci_pkg;
	localparam int ROW_W       = 12;
	localparam int COL_W       = 8;
	localparam int BANK_W      = 2;
	localparam int DATA_W      = 16;
	localparam int NUM_BANKS   = 4;
	localparam int MODE_W      = 12;
	localparam int AP_BIT      = 10;
	localparam int RD_MASK_LAT = 2;
	localparam int BURST_LEN   = 4;
	localparam int CLK_MHZ     = 200;
	localparam int PRECHARGE_WAIT_NS     = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 70;
	localparam int SELF_REFRESH_MIN_NS   = 45;
	localparam int SR_EXIT_NOPS          = 2;
	localparam int PRECHARGE_WAIT_CYC =
		(PRECHARGE_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int REFRESH_CYCLE_CYC =
		(REFRESH_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SELF_REFRESH_MIN_CYC =
		(SELF_REFRESH_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int REFRESH_COUNT     = 4096;
	localparam int REFRESH_WINDOW_MS = 64;
	localparam int REFRESH_INTERVAL_CYC =
		(REFRESH_WINDOW_MS * CLK_MHZ * 1000) / REFRESH_COUNT;
	// command code {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDCI_CMD_INHIBIT   = 4'h8,
		SDCI_CMD_NOP       = 4'h7,
		SDCI_CMD_ACTIVE    = 4'h3,
		SDCI_CMD_READ      = 4'h5,
		SDCI_CMD_WRITE     = 4'h4,
		SDCI_CMD_BURST_END = 4'h6,
		SDCI_CMD_PRECHARGE = 4'h2,
		SDCI_CMD_REFRESH   = 4'h1,
		SDCI_CMD_LOAD_MODE = 4'h0
	} sdci_cmd_t;
	localparam logic [ROW_W-1:0] ROW_ZERO = 12'h000;
endpackage : sdci_pkg

// ==== hw/sdci_if.sv ====
// pin bundle between sdram device model and memory controller
`timescale 1ns/10ps
interface sdci_if;
	import sdci_pkg::*;
	logic                   clk_gate;
	logic                   chip_select_n;
	logic                   row_strobe_n;
	logic                   col_strobe_n;
	logic                   write_strobe_n;
	logic [ROW_W-1:0]       address_lines;
	logic [BANK_W-1:0]      bank_select_lines;
	logic                   low_byte_mask;
	logic                   high_byte_mask;
	logic [DATA_W-1:0]      ctrl_data_out;
	logic                   ctrl_data_oe;
	logic [DATA_W-1:0]      dev_data_out;
	logic [1:0]             dev_data_oe;
	modport device (
		input  clk_gate, chip_select_n, row_strobe_n, col_strobe_n,
		input  write_strobe_n, address_lines, bank_select_lines,
		input  low_byte_mask, high_byte_mask, ctrl_data_out, ctrl_data_oe,
		output dev_data_out, dev_data_oe
	);
	modport ctrl (
		output clk_gate, chip_select_n, row_strobe_n, col_strobe_n,
		output write_strobe_n, address_lines, bank_select_lines,
		output low_byte_mask, high_byte_mask, ctrl_data_out, ctrl_data_oe,
		input  dev_data_out, dev_data_oe
	);
endinterface : sdci_if

// ==== hw/sdci_ctrl.sv ====
// memory controller end: issues commands with required waits
`timescale 1ns/10ps
module sdci_ctrl
	import sdci_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	sdci_if.ctrl                      pins,
	input  wire logic                 req_valid,
	input  wire sdci_cmd_t            req_cmd,
	input  wire logic [ROW_W-1:0]     req_addr,
	input  wire logic [BANK_W-1:0]    req_bank,
	input  wire logic [1:0]           req_mask,
	input  wire logic [DATA_W-1:0]    req_wdata,
	input  wire logic                 req_self_refresh,
	output logic                      req_ready,
	output logic     [DATA_W-1:0]     rd_data,
	output logic                      rd_valid
);
	logic [7:0]  wait_cnt, next_wait_cnt;
	logic        in_sr, next_in_sr;
	logic [15:0] ref_cnt, next_ref_cnt;
	logic        ref_due, next_ref_due;
	logic        cmd_go;
	always_comb begin
		req_ready = (wait_cnt == 8'h00) && !in_sr && !ref_due;
		cmd_go = req_valid && req_ready;
		next_wait_cnt = (wait_cnt != 8'h00) ? wait_cnt - 8'h01 : 8'h00;
		next_in_sr = in_sr;
		next_ref_cnt = ref_cnt + 16'h0001;
		next_ref_due = ref_due;
		if (ref_cnt == 16'(REFRESH_INTERVAL_CYC - 1))
			next_ref_cnt = 16'h0000;
		if (in_sr) begin
			if (!req_self_refresh && wait_cnt == 8'h00) begin
				next_in_sr = 1'b0;
				next_wait_cnt = 8'(REFRESH_CYCLE_CYC);
				next_ref_due = 1'b1;
			end
		end else if (ref_due && wait_cnt == 8'h00) begin
			next_ref_due = 1'b0;
			next_wait_cnt = 8'(REFRESH_CYCLE_CYC);
		end else if (cmd_go) begin
			if (req_cmd == SDCI_CMD_PRECHARGE)
				next_wait_cnt = 8'(PRECHARGE_WAIT_CYC);
			else if (req_cmd == SDCI_CMD_REFRESH && req_self_refresh) begin
				next_in_sr = 1'b1;
				next_wait_cnt = 8'(SELF_REFRESH_MIN_CYC);
			end else if (req_cmd == SDCI_CMD_REFRESH)
				next_wait_cnt = 8'(REFRESH_CYCLE_CYC);
		end
		// new interval wins over a refresh issued in the same cycle
		if (ref_cnt == 16'(REFRESH_INTERVAL_CYC - 1))
			next_ref_due = 1'b1;
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wait_cnt <= 8'h00;
			in_sr <= 1'b0;
			ref_cnt <= 16'h0000;
			ref_due <= 1'b0;
			pins.clk_gate <= 1'b1;
			pins.chip_select_n <= 1'b1;
			pins.row_strobe_n <= 1'b1;
			pins.col_strobe_n <= 1'b1;
			pins.write_strobe_n <= 1'b1;
			pins.address_lines <= '0;
			pins.bank_select_lines <= '0;
			pins.low_byte_mask <= 1'b1;
			pins.high_byte_mask <= 1'b1;
			pins.ctrl_data_out <= '0;
			pins.ctrl_data_oe <= 1'b0;
			rd_data <= '0;
			rd_valid <= 1'b0;
		end else begin
			wait_cnt <= next_wait_cnt;
			in_sr <= next_in_sr;
			ref_cnt <= next_ref_cnt;
			ref_due <= next_ref_due;
			// nops while waiting; gate low only in self refresh
			{pins.chip_select_n, pins.row_strobe_n, pins.col_strobe_n,
				pins.write_strobe_n} <= SDCI_CMD_NOP;
			pins.clk_gate <= !next_in_sr;
			if (!in_sr && ref_due && wait_cnt == 8'h00)
				{pins.chip_select_n, pins.row_strobe_n, pins.col_strobe_n,
					pins.write_strobe_n} <= SDCI_CMD_REFRESH;
			else if (cmd_go)
				{pins.chip_select_n, pins.row_strobe_n, pins.col_strobe_n,
					pins.write_strobe_n} <= req_cmd;
			pins.address_lines <= req_addr;
			pins.bank_select_lines <= req_bank;
			{pins.high_byte_mask, pins.low_byte_mask} <= req_mask;
			pins.ctrl_data_out <= req_wdata;
			pins.ctrl_data_oe <= cmd_go && req_cmd == SDCI_CMD_WRITE;
			rd_data <= pins.dev_data_out;
			rd_valid <= |pins.dev_data_oe;
		end
	end
endmodule : sdci_ctrl

// ==== tb/sdci_sva.sv ====
// pin-level assertions between the device and controller ends
`timescale 1ns/10ps
module sdci_sva
	import sdci_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       clk_gate,
	input  wire logic       chip_select_n,
	input  wire logic       row_strobe_n,
	input  wire logic       col_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic       low_byte_mask,
	input  wire logic       high_byte_mask,
	input  wire logic       ctrl_data_oe,
	input  wire logic [1:0] dev_data_oe
);
	logic [3:0] cmd;
	logic       idle;
	logic       gate_q;
	logic [4:0] hold;
	logic [4:0] next_hold;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	assign cmd = {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n};
	assign idle = chip_select_n || cmd == SDCI_CMD_NOP;
	// cycles left where only idle commands may follow
	always_comb begin
		next_hold = (hold != 5'h0) ? hold - 5'h1 : 5'h0;
		if ((cmd == SDCI_CMD_REFRESH && clk_gate) || (clk_gate && !gate_q))
			next_hold = 5'(REFRESH_CYCLE_CYC - 1);
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hold <= 5'h0;
			gate_q <= 1'b1;
		end else begin
			hold <= next_hold;
			gate_q <= clk_gate;
		end
	end
	property p_refresh_wait;
		hold != 5'h0 |-> idle;
	endproperty
	a_refresh_wait: assert property (p_refresh_wait)
		else $error("command inside refresh cycle time");
	property p_pre_wait;
		cmd == SDCI_CMD_PRECHARGE |=> idle [*3];
	endproperty
	a_pre_wait: assert property (p_pre_wait)
		else $error("command inside precharge wait");
	property p_sr_min;
		$fell(clk_gate) |=> !clk_gate [*8];
	endproperty
	a_sr_min: assert property (p_sr_min)
		else $error("self refresh left too early");
	property p_sr_entry;
		$fell(clk_gate) |-> cmd == SDCI_CMD_REFRESH;
	endproperty
	a_sr_entry: assert property (p_sr_entry)
		else $error("gate lowered without refresh code");
	property p_sr_exit;
		$rose(clk_gate) |-> idle ##1 idle;
	endproperty
	a_sr_exit: assert property (p_sr_exit)
		else $error("no idle pair after self refresh");
	property p_rd_lat;
		cmd == SDCI_CMD_READ && clk_gate ##1 !low_byte_mask && !high_byte_mask
			|-> ##2 dev_data_oe == 2'b11;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read word not driven on time");
	property p_rd_mask;
		(dev_data_oe & $past({high_byte_mask, low_byte_mask}, 2)) == 2'b00;
	endproperty
	a_rd_mask: assert property (p_rd_mask)
		else $error("masked lane driven");
	property p_no_clash;
		!(ctrl_data_oe && dev_data_oe != 2'b00);
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive data");
	c_self: cover property (cmd == SDCI_CMD_REFRESH && !clk_gate);
	c_stop: cover property (cmd == SDCI_CMD_BURST_END);
	c_half: cover property (dev_data_oe == 2'b01);
endmodule : sdci_sva

// ==== tb/sdram_command_interface_tb.sv ====
// bench joining device and controller ends through the pin bundle
`timescale 1ns/10ps
module sdram_command_interface_tb;
	import sdci_pkg::*;
	typedef struct {
		sdci_cmd_t   cmd;
		logic [11:0] addr;
		logic [1:0]  bank;
		logic [1:0]  mask;
		logic [15:0] data;
		int          nrd;
		logic [3:0]  bopen;
		logic [11:0] mexp;
	} sdci_row_t;
	sdci_row_t rows [17] = '{
		'{SDCI_CMD_LOAD_MODE, 12'h023, 2'h0, 2'h3, 16'h0000, 0, 4'h0, 12'h023},
		'{SDCI_CMD_ACTIVE, 12'h005, 2'h1, 2'h3, 16'h0000, 0, 4'h2, 12'h023},
		'{SDCI_CMD_LOAD_MODE, 12'h031, 2'h0, 2'h3, 16'h0000, 0, 4'h2, 12'h023},
		'{SDCI_CMD_INHIBIT, 12'h007, 2'h2, 2'h3, 16'h0000, 0, 4'h2, 12'h023},
		'{SDCI_CMD_WRITE, 12'h010, 2'h1, 2'h0, 16'hA5C3, 0, 4'h2, 12'h023},
		'{SDCI_CMD_WRITE, 12'h010, 2'h1, 2'h1, 16'h12FF, 0, 4'h2, 12'h023},
		'{SDCI_CMD_READ, 12'h010, 2'h1, 2'h0, 16'h12C3, 4, 4'h2, 12'h023},
		'{SDCI_CMD_READ, 12'h010, 2'h1, 2'h2, 16'h12C3, 4, 4'h2, 12'h023},
		'{SDCI_CMD_READ, 12'h410, 2'h1, 2'h0, 16'h12C3, 4, 4'h0, 12'h023},
		'{SDCI_CMD_ACTIVE, 12'h005, 2'h1, 2'h0, 16'h0000, 0, 4'h2, 12'h023},
		'{SDCI_CMD_READ, 12'h010, 2'h1, 2'h0, 16'h12C3, 4, 4'h2, 12'h023},
		'{SDCI_CMD_WRITE, 12'h420, 2'h1, 2'h0, 16'h5AA5, 0, 4'h0, 12'h023},
		'{SDCI_CMD_ACTIVE, 12'h007, 2'h2, 2'h0, 16'h0000, 0, 4'h4, 12'h023},
		'{SDCI_CMD_ACTIVE, 12'h009, 2'h3, 2'h0, 16'h0000, 0, 4'hC, 12'h023},
		'{SDCI_CMD_PRECHARGE, 12'h000, 2'h2, 2'h0, 16'h0000, 0, 4'h8, 12'h023},
		'{SDCI_CMD_PRECHARGE, 12'h400, 2'h0, 2'h0, 16'h0000, 0, 4'h0, 12'h023},
		'{SDCI_CMD_LOAD_MODE, 12'h031, 2'h0, 2'h0, 16'h0000, 0, 4'h0, 12'h031}
	};
	logic        mclk, resetn, req_valid, req_self_refresh, req_ready;
	logic        rd_valid, self_refresh;
	sdci_cmd_t   req_cmd;
	logic [11:0] req_addr, mode_reg, refresh_row, r;
	logic [1:0]  req_bank, req_mask;
	logic [15:0] req_wdata, rd_data, exp_word, lane;
	logic [3:0]  bank_open;
	int          n_fail = 0, check_count = 0, n_words = 0, cycles = 0;
	sdci_if sdci_if_i ();
	sdci_device sdci_device_i (.mclk(mclk), .resetn(resetn), .pins(sdci_if_i),
		.mode_reg(mode_reg), .bank_open(bank_open),
		.self_refresh(self_refresh), .refresh_row(refresh_row));
	sdci_ctrl sdci_ctrl_i (.mclk(mclk), .resetn(resetn), .pins(sdci_if_i),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
		.req_bank(req_bank), .req_mask(req_mask), .req_wdata(req_wdata),
		.req_self_refresh(req_self_refresh), .req_ready(req_ready),
		.rd_data(rd_data), .rd_valid(rd_valid));
	sdci_sva sdci_sva_i (.mclk(mclk), .resetn(resetn),
		.clk_gate(sdci_if_i.clk_gate), .chip_select_n(sdci_if_i.chip_select_n),
		.row_strobe_n(sdci_if_i.row_strobe_n),
		.col_strobe_n(sdci_if_i.col_strobe_n),
		.write_strobe_n(sdci_if_i.write_strobe_n),
		.low_byte_mask(sdci_if_i.low_byte_mask),
		.high_byte_mask(sdci_if_i.high_byte_mask),
		.ctrl_data_oe(sdci_if_i.ctrl_data_oe),
		.dev_data_oe(sdci_if_i.dev_data_oe));
	always #2.5 mclk = ~mclk;
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// one request, taken at the edge after a ready negedge
	task automatic issue(input sdci_cmd_t c, input logic [11:0] a,
		input logic [1:0] b, input logic [1:0] m, input logic [15:0] d);
		int k;
		k = 0;
		@(negedge mclk);
		while (req_ready !== 1'b1 && k < 100) begin
			@(negedge mclk);
			k++;
		end
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		req_bank = b;
		req_mask = m;
		req_wdata = d;
		@(negedge mclk);
		req_valid = 1'b0;
	endtask : issue
	always @(negedge mclk)
		if (rd_valid === 1'b1) begin
			n_words++;
			check(((rd_data ^ exp_word) & lane) === 16'h0000, "read word");
		end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish();
		end
	end
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		req_valid = 1'b0;
		req_self_refresh = 1'b0;
		req_cmd = SDCI_CMD_NOP;
		req_addr = 12'h000;
		req_bank = 2'h0;
		req_mask = 2'h3;
		req_wdata = 16'h0000;
		repeat (4) @(posedge mclk);
		@(negedge mclk) resetn = 1'b1;
		check(bank_open === 4'h0 && mode_reg === 12'h000, "reset state");
		$display("test reset done");
		foreach (rows[i]) begin
			n_words = 0;
			exp_word = rows[i].data;
			lane = ~{{8{rows[i].mask[1]}}, {8{rows[i].mask[0]}}};
			issue(rows[i].cmd, rows[i].addr, rows[i].bank, rows[i].mask,
				rows[i].data);
			repeat (12) @(negedge mclk);
			check(n_words == rows[i].nrd, "word count");
			check(bank_open === rows[i].bopen, "bank state");
			check(mode_reg === rows[i].mexp, "mode copy");
			$display("test row %0d done", i);
		end
		exp_word = 16'h12C3;
		lane = 16'hFFFF;
		n_words = 0;
		issue(SDCI_CMD_ACTIVE, 12'h005, 2'h1, 2'h0, 16'h0000);
		issue(SDCI_CMD_READ, 12'h010, 2'h1, 2'h0, 16'h0000);
		issue(SDCI_CMD_BURST_END, 12'h000, 2'h0, 2'h0, 16'h0000);
		repeat (12) @(negedge mclk);
		check(n_words > 0 && n_words < 4, "burst cut");
		$display("test burst stop done");
		issue(SDCI_CMD_PRECHARGE, 12'h400, 2'h0, 2'h0, 16'h0000);
		r = refresh_row;
		issue(SDCI_CMD_REFRESH, 12'hFFF, 2'h3, 2'h0, 16'h0000);
		repeat (4) @(negedge mclk);
		check(refresh_row === r + 12'h001, "auto refresh");
		req_self_refresh = 1'b1;
		issue(SDCI_CMD_REFRESH, 12'h000, 2'h0, 2'h0, 16'h0000);
		repeat (20) @(negedge mclk);
		check(self_refresh === 1'b1, "self refresh on");
		req_self_refresh = 1'b0;
		repeat (30) @(negedge mclk);
		check(self_refresh === 1'b0, "self refresh off");
		issue(SDCI_CMD_ACTIVE, 12'h005, 2'h1, 2'h0, 16'h0000);
		repeat (6) @(negedge mclk);
		check(bank_open === 4'h2, "open after exit");
		$display("test refresh done");
		tally_and_finish();
	end
endmodule : sdram_command_interface_tb
